// *** bench/tb_timer_based_pwm_output.sv ***
// Self-checking testbench of the timer-based PWM output.
module tb_timer_based_pwm_output import tbpwm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic ext_clk = 1'b0;
    logic ext_run = 1'b0;
    logic [2:0] ext_div = 3'h0;
    tbpwm_apb_req_s apb_req = '0;
    tbpwm_apb_rsp_s apb_rsp;
    logic pwm_out;
    logic tmr_irq;
    logic [31:0] q;
    logic e;
    int hi_cnt;
    int per_cnt;
    int n_per;
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;

    always #5 pclk = ~pclk;

    tbpwm_core dut (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .ext_clk(ext_clk),
        .pwm_out(pwm_out),
        .tmr_irq(tmr_irq)
    );

    tbpwm_load load (
        .pclk(pclk),
        .pwm_out(pwm_out),
        .hi_cnt(hi_cnt),
        .per_cnt(per_cnt),
        .n_per(n_per)
    );

    // External timer clock: 14 pclk per period, so it is already synchronous.
    always @(posedge pclk)
        if (ext_run)
        begin
            ext_div <= (ext_div == 3'h6) ? 3'h0 : ext_div + 3'h1;
            if (ext_div == 3'h6)
                ext_clk <= ~ext_clk;
        end

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            fails++;
            summarize();
        end
    end

    // ====================================================================
    // Bus and checking helpers.
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    task automatic chk(input string w, input logic [31:0] x,
        input logic [31:0] g, input logic [31:0] t);
        checks_done++;
        if ((g >= x && g <= x + t) !== 1'b1)
        begin
            fails++;
            $display("mismatch %s exp %h got %h", w, x, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        apb_req.psel <= 1'b1;
        apb_req.pwrite <= w;
        apb_req.paddr <= a;
        apb_req.pwdata <= d;
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        @(posedge pclk);
        while (apb_rsp.pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input string w, input logic [11:0] a,
        input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(w, x, q, 32'h0);
    endtask : rdc

    task automatic wm();
        int k;
        int n;
        k = n_per;
        n = 0;
        while (n_per == k && n < 5000)
        begin
            n++;
            @(posedge pclk);
        end
        if (n_per == k)
        begin
            fails++;
            $display("mismatch rise exp %0d got %0d", k + 1, n_per);
        end
    endtask : wm

    // ====================================================================
    // Scenarios.
    task automatic t_reset();
        rdc("tmr", ADR_TMR, {24'h0, RST_TMR});
        rdc("per", ADR_PER, {24'h0, RST_PER});
        rdc("duty_lo", ADR_DUTY_LO, {24'h0, RST_DUTY});
        rdc("duty_hi", ADR_DUTY_HI, {24'h0, RST_DUTY});
        rdc("ctl", ADR_CTL, 32'h0);
        rdc("isc", ADR_ISC, 32'h0);
        apb(1'b1, 12'h3fc, 32'h5a);
        chk("slverr", 32'h1, {31'h0, e}, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_duty();
        int k;
        wr(ADR_PER, 32'h1f);
        wr(ADR_DUTY_LO, 32'h80);
        wr(ADR_DUTY_HI, 32'h07);
        wr(ADR_CTL, 32'h5);
        repeat (3) wm();
        chk("per", 32'd128, per_cnt, 32'h0);
        chk("hi", 32'd30, hi_cnt, 32'h1);
        wr(ADR_DUTY_LO, 32'hc0);
        repeat (60) @(posedge pclk);
        chk("hi_now", 32'd30, hi_cnt, 32'h1);
        repeat (2) wm();
        chk("hi_split", 32'd31, hi_cnt, 32'h1);
        wr(ADR_DUTY_HI, 32'h09);
        repeat (2) wm();
        chk("hi_high", 32'd39, hi_cnt, 32'h1);
        wr(ADR_DUTY_HI, 32'h20);
        wm();
        k = n_per;
        repeat (260) @(posedge pclk);
        chk("full", 32'h1, {31'h0, pwm_out}, 32'h0);
        chk("full_n", k, n_per, 32'h0);
        wr(ADR_DUTY_HI, 32'h07);
        $display("test duty done");
    endtask : t_duty

    task automatic t_period();
        wm();
        wr(ADR_PER, 32'h7f);
        repeat (2) wm();
        chk("per_long", 32'd512, per_cnt, 32'h0);
        wr(ADR_ISC, 32'h1);
        repeat (250) @(posedge pclk);
        wr(ADR_PER, 32'h1f);
        repeat (200) @(posedge pclk);
        apb(1'b0, ADR_TMR, 32'h0);
        chk("tmr_on", 32'h0, {31'h0, e}, 32'h0);
        chk("tmr_run", 32'h68, q, 32'h18);
        rdc("no_flag", ADR_ISC, 32'h0);
        wm();
        chk("wrap", 32'd1152, per_cnt, 32'h0);
        wm();
        chk("per_new", 32'd128, per_cnt, 32'h0);
        $display("test period done");
    endtask : t_period

    task automatic t_irq();
        wr(ADR_ISC, 32'h3);
        chk("irq_clr", 32'h0, {31'h0, tmr_irq}, 32'h0);
        wm();
        repeat (3) @(posedge pclk);
        chk("irq_on", 32'h1, {31'h0, tmr_irq}, 32'h0);
        rdc("isc_on", ADR_ISC, 32'h3);
        wr(ADR_ISC, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq_mask", 32'h0, {31'h0, tmr_irq}, 32'h0);
        rdc("sticky", ADR_ISC, 32'h1);
        wr(ADR_ISC, 32'h1);
        rdc("isc_clr", ADR_ISC, 32'h0);
        $display("test irq done");
    endtask : t_irq

    task automatic t_ext();
        int p1;
        wr(ADR_CTL, 32'h7);
        rdc("ctl", ADR_CTL, 32'h7);
        wr(ADR_TMR, 32'h05);
        repeat (100) @(posedge pclk);
        rdc("tmr_hold", ADR_TMR, 32'h05);
        ext_run <= 1'b1;
        repeat (3) wm();
        p1 = per_cnt;
        chk("ext_per", 32'd447, p1, 32'h2);
        wm();
        chk("jitter", p1, per_cnt, 32'h0);
        wr(ADR_CTL, 32'h3);
        repeat (3) @(posedge pclk);
        chk("out_off", 32'h0, {31'h0, pwm_out}, 32'h0);
        $display("test ext done");
    endtask : t_ext

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_duty();
        t_period();
        t_irq();
        t_ext();
        summarize();
    end
endmodule : tb_timer_based_pwm_output

// *** bench/tbpwm_load.sv ***
// Load model on the PWM output: measures high time and period in pclk cycles.
module tbpwm_load (
    input wire logic pclk,
    input wire logic pwm_out,
    output int hi_cnt,
    output int per_cnt,
    output int n_per
);
    timeunit 1ns;
    timeprecision 1ps;
    int hi_run = 0;
    int per_run = 0;
    logic last = 1'b0;
    initial
    begin
        hi_cnt = 0;
        per_cnt = 0;
        n_per = 0;
    end
    // A period is measured rise to rise, so a full-duty output shows none.
    always @(posedge pclk)
    begin
        if (pwm_out && !last)
        begin
            per_cnt <= per_run;
            n_per <= n_per + 1;
            per_run <= 1;
            hi_run <= 1;
        end
        else
        begin
            per_run <= per_run + 1;
            if (pwm_out)
                hi_run <= hi_run + 1;
        end
        if (!pwm_out && last)
            hi_cnt <= hi_run;
        last <= pwm_out;
    end
endmodule : tbpwm_load

// *** core/tbpwm_core.sv ***
// Timer-based PWM generator with double-buffered duty and APB registers.
//
// Register access over APB was decided locally.
module tbpwm_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire tbpwm_pkg::tbpwm_apb_req_s apb_req,
    output tbpwm_pkg::tbpwm_apb_rsp_s apb_rsp,
    input wire logic ext_clk,
    output logic pwm_out,
    output logic tmr_irq
);
    import tbpwm_pkg::*;

    typedef struct packed {
        logic [7:0] tmr;
        logic [1:0] qph;
        logic [7:0] per;
        logic [7:0] duty_lo;
        logic [7:0] duty_hi;
        logic [9:0] act;
        logic [2:0] ctl;
        logic flg;
        logic ien;
        logic pwm;
        logic irq;
        tbpwm_apb_rsp_s rsp;
    } tbpwm_core_s;

    tbpwm_core_s st_ff;
    tbpwm_core_s nxt_st;

    logic ext_rise;
    logic setup;
    logic wr;
    logic hit;
    logic tick;
    logic match;
    logic full_duty;
    logic [9:0] fine;
    logic [31:0] rd;

    // ========================================================================
    // External clock synchroniser.
    tbpwm_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .ext_clk(ext_clk),
        .ext_rise(ext_rise)
    );

    // ========================================================================
    // Bus decode. The answer is registered, so every access has exactly one
    // access-phase cycle; this keeps all bus outputs on flip-flops.
    assign setup = apb_req.psel && !apb_req.penable;
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite
        && st_ff.rsp.pready;

    always_comb
    begin
        hit = 1'b1;
        rd = 32'h0;
        case (apb_req.paddr)
            ADR_ISC:
            begin
                rd[ISC_FLG_BIT] = st_ff.flg;
                rd[ISC_IEN_BIT] = st_ff.ien;
            end
            ADR_TMR: rd[7:0] = st_ff.tmr;
            ADR_DUTY_LO: rd[7:0] = st_ff.duty_lo;
            ADR_DUTY_HI: rd[7:0] = st_ff.duty_hi;
            ADR_PER: rd[7:0] = st_ff.per;
            ADR_CTL: rd[2:0] = st_ff.ctl;
            default: hit = 1'b0;
        endcase
    end

    // ========================================================================
    // Timebase. The internal source steps once per instruction cycle; the
    // external one steps on a synchronised edge, which can land anywhere in
    // the instruction cycle; the phase restarts there, so a synchronous source sees no jitter.
    assign tick = st_ff.ctl[CTL_ON_BIT] && (st_ff.ctl[CTL_EXT_BIT]
        ? ext_rise : (st_ff.qph == QPH_LAST));
    // Only equality matches, so a count above the period runs on.
    assign match = tick && (st_ff.tmr == st_ff.per);
    assign fine = {st_ff.tmr, st_ff.qph};
    assign full_duty = st_ff.act[9:2] >= st_ff.per;

    always_comb
    begin
        nxt_st = st_ff;
        if (ce)
        begin
            // Bus answer.
            nxt_st.rsp.pready = setup;
            nxt_st.rsp.pslverr = setup && !hit;
            nxt_st.rsp.prdata = (setup && !apb_req.pwrite) ? rd : 32'h0;

            // Quarter-cycle phase restarts on every timer step.
            if (tick)
            begin
                nxt_st.qph = 2'h0;
            end
            else if (st_ff.qph != QPH_LAST)
            begin
                nxt_st.qph = 2'(st_ff.qph + 2'h1);
            end

            // Timer: clear on match, otherwise count and wrap at ffh.
            if (match)
            begin
                nxt_st.tmr = 8'h00;
            end
            else if (tick)
            begin
                nxt_st.tmr = 8'(st_ff.tmr + 8'h01);
            end

            // Active duty is loaded from the buffers only here; a half-done
            // two-write update is taken as it stands and the rest follows at
            // the next match.
            if (match)
            begin
                nxt_st.act = {st_ff.duty_hi,
                    st_ff.duty_lo[DUTY_LO_LSB_POS+1:DUTY_LO_LSB_POS]};
                // Mixed old and new halves.
            end

            // Output.
            if (!st_ff.ctl[CTL_EN_BIT])
            begin
                nxt_st.pwm = 1'b0;
            end
            else if (match)
            begin
                nxt_st.pwm = 1'b1;
            end
            else if (fine == st_ff.act && !full_duty)
            begin
                nxt_st.pwm = 1'b0;
            end

            // Register writes; a timer write wins over the count.
            if (wr)
            begin
                case (apb_req.paddr)
                    ADR_ISC:
                    begin
                        nxt_st.ien = apb_req.pwdata[ISC_IEN_BIT];
                        if (apb_req.pwdata[ISC_FLG_BIT])
                        begin
                            nxt_st.flg = 1'b0;
                        end
                    end
                    ADR_TMR: nxt_st.tmr = apb_req.pwdata[7:0];
                    ADR_DUTY_LO: nxt_st.duty_lo = apb_req.pwdata[7:0];
                    ADR_DUTY_HI: nxt_st.duty_hi = apb_req.pwdata[7:0];
                    ADR_PER: nxt_st.per = apb_req.pwdata[7:0];
                    ADR_CTL: nxt_st.ctl = apb_req.pwdata[2:0];
                    default:
                    begin
                    end
                endcase
            end

            // Match flag: the set wins over a clear in the same cycle.
            if (match)
            begin
                nxt_st.flg = 1'b1;
            end
            nxt_st.irq = nxt_st.flg && nxt_st.ien;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= '0;
            st_ff.tmr <= RST_TMR;
            st_ff.per <= RST_PER;
            st_ff.duty_lo <= RST_DUTY;
            st_ff.duty_hi <= RST_DUTY;
            st_ff.ctl <= RST_CTL;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign apb_rsp = st_ff.rsp;
    assign pwm_out = st_ff.pwm;
    assign tmr_irq = st_ff.irq;

    // ========================================================================
    // Assertions.
    logic wr_tmr;
    logic wr_ctl;
    assign wr_tmr = wr && (apb_req.paddr == ADR_TMR);
    assign wr_ctl = wr && (apb_req.paddr == ADR_CTL);

    sequence s_pin_rise;
        (ce && !ext_clk) ##1 (ce && ext_clk) ##1 ce;
    endsequence

    sequence s_latch;
        ce && match ##1 1'b1;
    endsequence

    AST_ACT_ONLY_AT_MATCH: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_ff.act != $past(st_ff.act)) |-> $past(match && ce))
        else $error("Active duty changed without a period match.");

    AST_DUTY_WRITE_BUFFERED: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && wr && !match && (apb_req.paddr == ADR_DUTY_HI))
        |=> (st_ff.act == $past(st_ff.act))
            && (st_ff.duty_hi == $past(apb_req.pwdata[7:0])))
        else $error("Duty write reached the active value directly.");

    AST_LATCH_SPLIT: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_latch |-> st_ff.act == {$past(st_ff.duty_hi),
            $past(st_ff.duty_lo[DUTY_LO_LSB_POS+1:DUTY_LO_LSB_POS])})
        else $error("Latched duty does not join the two buffers.");

    AST_PERIOD_LIVE: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && wr && apb_req.paddr == ADR_PER)
        |=> st_ff.per == $past(apb_req.pwdata[7:0]))
        else $error("Period write did not take effect at once.");

    AST_RUN_PAST_PERIOD: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && tick && st_ff.tmr > st_ff.per && !wr_tmr)
        |=> st_ff.tmr == 8'($past(st_ff.tmr) + 8'h01) && !st_ff.rsp.pslverr
            || st_ff.tmr == 8'($past(st_ff.tmr) + 8'h01))
        else $error("Timer cleared above the period.");

    AST_WRAP: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && tick && st_ff.tmr == 8'hff && st_ff.per != 8'hff && !wr_tmr)
        |=> st_ff.tmr == 8'h00 && st_ff.act == $past(st_ff.act))
        else $error("Timer did not wrap from ffh or matched there.");

    AST_CLEAR_ON_MATCH: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && match && !wr_tmr && !wr_ctl && st_ff.ctl[CTL_EN_BIT])
        |=> st_ff.tmr == 8'h00 && st_ff.pwm && st_ff.flg)
        else $error("Match did not clear timer and raise output.");

    AST_FULL_DUTY_HIGH: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_ff.pwm && full_duty && !wr_ctl)
        |=> st_ff.pwm)
        else $error("Output fell although duty is at or above period.");

    AST_IRQ_FORWARD: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && match && st_ff.ien && !wr) |=> tmr_irq ##1 (tmr_irq || !ce
            || !st_ff.flg || !st_ff.ien || $past(wr)))
        else $error("Match flag not forwarded to the interrupt output.");

    AST_EXT_SYNC: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_pin_rise |=> ext_rise)
        else $error("External edge not seen two cycles after sampling.");

endmodule : tbpwm_core

// *** core/tbpwm_pkg.sv ***
// Constants, bus carriers and register map of the timer-based PWM output.
// Function
// - Duty writes go to a buffer, not straight to the active duty value.
// - Buffered duty is copied to the active value only on timer-equals-period.
// - Period register is unbuffered; a write is the compare value at once.
// - Period below count: no duty latch and no timer clear until a match.
// - Timer then runs to ffh, wraps to 00h and matches at new period.
// - Duty is ten bits, split over high and low registers, two writes.
// - Match after low write only: old high part with new low part.
// - Match after high write only: new high part with old low part.
// - The second-written duty register is taken at the following match.
// - A split update with the high register written first errs by at most three quarter-cycles for one period.
// - Software selects instruction clock or external clock as timer source.
// - External timer clock is synchronised; every step on an internal edge.
// - Asynchronous external clock adds up to one instruction cycle error.
// - Synchronous external clock gives a constant error and no jitter.
// - Active duty at or above period keeps the output high all period.
package tbpwm_pkg;

    // ========================================================================
    // Register indices; byte address is four times the index.
    localparam logic [7:0] IDX_ISC = 8'h06;
    localparam logic [7:0] IDX_TMR = 8'h10;
    localparam logic [7:0] IDX_DUTY_LO = 8'h11;
    localparam logic [7:0] IDX_DUTY_HI = 8'h12;
    localparam logic [7:0] IDX_PER = 8'h14;
    localparam logic [7:0] IDX_CTL = 8'h16;
    localparam logic [11:0] ADR_ISC = {2'h0, IDX_ISC, 2'h0};
    localparam logic [11:0] ADR_TMR = {2'h0, IDX_TMR, 2'h0};
    localparam logic [11:0] ADR_DUTY_LO = {2'h0, IDX_DUTY_LO, 2'h0};
    localparam logic [11:0] ADR_DUTY_HI = {2'h0, IDX_DUTY_HI, 2'h0};
    localparam logic [11:0] ADR_PER = {2'h0, IDX_PER, 2'h0};
    localparam logic [11:0] ADR_CTL = {2'h0, IDX_CTL, 2'h0};

    // ========================================================================
    // Field positions.
    localparam int ISC_FLG_BIT = 0;
    localparam int ISC_IEN_BIT = 1;
    localparam int CTL_ON_BIT = 0;
    localparam int CTL_EXT_BIT = 1;
    localparam int CTL_EN_BIT = 2;
    localparam int DUTY_LO_LSB_POS = 6;

    // ========================================================================
    // Values after reset.
    localparam logic [7:0] RST_TMR = 8'h00;
    localparam logic [7:0] RST_PER = 8'hff;
    localparam logic [7:0] RST_DUTY = 8'h00;
    localparam logic [2:0] RST_CTL = 3'h0;

    // ========================================================================
    // Timing: one instruction cycle is four quarter-cycles of pclk.
    localparam int CLK_NS = 10;
    localparam int INSTR_CY_NS = 40;
    localparam int Q_PER_CY = INSTR_CY_NS / CLK_NS;
    localparam logic [1:0] QPH_LAST = 2'(Q_PER_CY - 1);

    // ========================================================================
    // APB carriers.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } tbpwm_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tbpwm_apb_rsp_s;

endpackage : tbpwm_pkg

// *** core/tbpwm_sync.sv ***
// Synchroniser and rising-edge detector for the external timer clock.
module tbpwm_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic ext_clk,
    output logic ext_rise
);
    import tbpwm_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } tbpwm_sync_s;

    tbpwm_sync_s st_ff;
    tbpwm_sync_s nxt_st;

    // ========================================================================
    // Only the second stage reads the first; the edge uses stages two and
    // three, so the latency is fixed and a synchronous source sees no jitter.
    always_comb
    begin
        nxt_st = st_ff;
        if (ce)
        begin
            nxt_st.s1 = ext_clk;
            nxt_st.s2 = st_ff.s1;
            nxt_st.s3 = st_ff.s2;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign ext_rise = st_ff.s2 && !st_ff.s3;

endmodule : tbpwm_sync
